// File: core/tbd_pkg.sv
// Constants, field positions and fault codes for the tag bus decoder.
// Behaviour
// - Latch fault line for each listed condition.
// - Fault clear drops line, retract stays set.
// - Terminator line low when chain complete, ungated.
// - Detected address mark gives one low pulse.
// - Pulse only when mark enable set beforehand.
// - Status outputs except the terminator line gated by select within 200ns.
// - Cylinder tag: bus 0 weight 512, bus 9 LSB.
// - Head tag: bus 5-9 head address, bus 9 LSB.
// - Head tag bus 2 commands offset.
// - Bus 3 active means offset toward spindle.
// - Cancel offset on bus 2 inactive or rezero.
// - Head tag bus 6 selects removable media.
// - Control tag decodes ten command bits.
// - Cylinder tag trailing edge starts the seek.
// - Ready held off 2.4ms after offset command.
// - Rezero clears head, offset, non-retract faults.
package tbd_pkg;
	// Clock period used to turn times into cycle counts.
	localparam int CLK_PERIOD_NS = 10;
	// Ready hold-off after an offset command, in nanoseconds (2.4 ms).
	localparam int OFFSET_SETTLE_NS = 2400000;
	localparam int OFFSET_SETTLE_CYC = OFFSET_SETTLE_NS / CLK_PERIOD_NS;
	// Width of the bussed data lines.
	localparam int BUS_W = 10;
	// Number of latched fault causes.
	localparam int FLT_W = 10;
	// Fault latch bit positions.
	localparam int FLT_WRITE_UNSAFE = 0;
	localparam int FLT_CYL_NOT_READY = 1;
	localparam int FLT_RW_NOT_READY = 2;
	localparam int FLT_OFFSET_WRITE = 3;
	localparam int FLT_READ_AND_WRITE = 4;
	localparam int FLT_WRITE_PROTECT = 5;
	localparam int FLT_ILLEGAL_CYL = 6;
	localparam int FLT_GUARDBAND = 7;
	localparam int FLT_RETRACT = 8;
	localparam int FLT_SEEK_INC = 9;
	// Head tag bus line positions.
	localparam int HB_OFFSET = 2;
	localparam int HB_TOWARD_SPINDLE = 3;
	localparam int HB_MEDIA = 6;
	// Control tag bus line positions.
	localparam int CB_STROBE_LATE = 0;
	localparam int CB_STROBE_EARLY = 1;
	localparam int CB_WRITE = 2;
	localparam int CB_READ = 3;
	localparam int CB_MARK_ENABLE = 4;
	localparam int CB_HEAD_CLEAR = 5;
	localparam int CB_FAULT_CLEAR = 6;
	localparam int CB_HEAD_SELECT = 7;
	localparam int CB_REZERO = 8;
	localparam int CB_HEAD_STEP = 9;
	// APB register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FAULT = 8'h04;
	localparam logic [7:0] REG_CYL = 8'h08;
	localparam logic [7:0] REG_HEAD = 8'h0c;
	localparam logic [7:0] REG_CMD = 8'h10;
	// Reset values.
	localparam logic [FLT_W-1:0] FLT_RESET = 10'h000;
	localparam logic [BUS_W-1:0] CMD_RESET = 10'h000;
	localparam logic [4:0] HEAD_RESET = 5'h00;
endpackage

// File: core/tbd_decoder.sv
// Drive-side decoder for the bussed tag cable, with an APB status port.
`timescale 1ns/1ps
`default_nettype none
module tbd_decoder #(
	parameter int SETTLE_CYC = tbd_pkg::OFFSET_SETTLE_CYC
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave port.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Cable inputs, active low except terminator_chain_ok, which is active high.
	input wire logic cylinder_tag_n,
	input wire logic head_tag_n,
	input wire logic control_tag_n,
	input wire logic [tbd_pkg::BUS_W-1:0] bus_n,
	input wire logic drive_select_n,
	input wire logic terminator_chain_ok,
	// Drive condition inputs, active high, asynchronous to pclk.
	input wire logic heads_ready,
	input wire logic read_only,
	input wire logic address_mark_seen,
	input wire logic write_unsafe,
	input wire logic illegal_cylinder,
	input wire logic guardband_on_track,
	input wire logic emergency_retract,
	input wire logic seek_incomplete,
	// Cable outputs, active low.
	output logic fault_line_n,
	output logic terminator_present_n,
	output logic mark_found_pulse_n,
	output logic ready_n,
	// Commands to the drive's mechanics and data path.
	output logic [tbd_pkg::BUS_W-1:0] cylinder_addr,
	output logic seek_start,
	output logic [4:0] head_addr,
	output logic media_select,
	output logic offset_request,
	output logic offset_toward_spindle,
	output logic strobe_late,
	output logic strobe_early,
	output logic write_gate,
	output logic read_gate,
	output logic mark_enable,
	output logic head_select_enable,
	output logic rezero
);
	import tbd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Bus line 0 carries the top weight, so the vector is flipped.
	function automatic logic [BUS_W-1:0] flip_bus(input logic [BUS_W-1:0] b);
		logic [BUS_W-1:0] r;
		r = '0;
		for (int i = 0; i < BUS_W; i++) begin
			r[BUS_W-1-i] = b[i];
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers.

	// Everything from the cable and the analog side is asynchronous.
	localparam int SW = 3 + BUS_W + 10;
	logic [SW-1:0] raw_in;
	logic [SW-1:0] sync1_reg;
	logic [SW-1:0] sync2_reg;

	// Tags and bus are inverted here so that the logic works active high.
	assign raw_in = {~cylinder_tag_n, ~head_tag_n, ~control_tag_n, ~bus_n,
		~drive_select_n, terminator_chain_ok, heads_ready, read_only,
		address_mark_seen, write_unsafe, illegal_cylinder,
		guardband_on_track, emergency_retract, seek_incomplete};

	// Two stages; only the second stage is read by any logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end

	// Named views of the synchronised inputs.
	wire cyl_tag_s = sync2_reg[SW-1];
	wire head_tag_s = sync2_reg[SW-2];
	wire ctl_tag_s = sync2_reg[SW-3];
	wire [BUS_W-1:0] bus_s = sync2_reg[SW-4 -: BUS_W];
	wire select_s = sync2_reg[9];
	wire term_ok_s = sync2_reg[8];
	wire ready_s = sync2_reg[7];
	wire read_only_s = sync2_reg[6];
	wire mark_s = sync2_reg[5];
	wire wunsafe_s = sync2_reg[4];
	wire illcyl_s = sync2_reg[3];
	wire guard_s = sync2_reg[2];
	wire retract_s = sync2_reg[1];
	wire seekinc_s = sync2_reg[0];

	////////////////////////////////////////////////////////////////////////
	// Tag qualification.

	// A tag is only honoured while it is the sole tag low on the cable.
	wire cyl_only = cyl_tag_s & ~head_tag_s & ~ctl_tag_s;
	wire head_only = head_tag_s & ~cyl_tag_s & ~ctl_tag_s;
	wire ctl_only = ctl_tag_s & ~cyl_tag_s & ~head_tag_s;

	// Previous qualified tags, for leading and trailing edges.
	logic cyl_q_reg;
	logic head_q_reg;
	logic ctl_q_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyl_q_reg <= 1'b0;
			head_q_reg <= 1'b0;
			ctl_q_reg <= 1'b0;
		end else begin
			cyl_q_reg <= cyl_only;
			head_q_reg <= head_only;
			ctl_q_reg <= ctl_only;
		end
	end

	wire cyl_rise = cyl_only & ~cyl_q_reg;
	wire cyl_fall = cyl_q_reg & ~cyl_only;
	wire head_fall = head_q_reg & ~head_only;
	wire ctl_rise = ctl_only & ~ctl_q_reg;

	////////////////////////////////////////////////////////////////////////
	// Control tag: command bits.

	// Level bits persist until the next control tag rewrites them.
	logic [BUS_W-1:0] cmd_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= CMD_RESET;
		end else if (ctl_only) begin
			cmd_reg <= bus_s;
		end
	end

	// Action bits fire once, at the first decoded cycle of the tag.
	wire do_head_clear = ctl_rise & bus_s[CB_HEAD_CLEAR];
	wire do_rezero = ctl_rise & bus_s[CB_REZERO];
	wire do_head_step = ctl_rise & bus_s[CB_HEAD_STEP];
	logic sw_clear;
	wire do_fault_clear = (ctl_rise & bus_s[CB_FAULT_CLEAR]) | sw_clear;

	////////////////////////////////////////////////////////////////////////
	// Cylinder tag.

	// The address follows the bus while the tag stands; the seek waits
	// for the trailing edge so the controller can settle the lines.
	logic [BUS_W-1:0] cyl_reg;
	logic seek_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyl_reg <= '0;
			seek_reg <= 1'b0;
		end else begin
			if (cyl_only) begin
				cyl_reg <= flip_bus(bus_s);
			end
			seek_reg <= cyl_fall;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Head tag: head address, media and offset.

	wire [BUS_W-1:0] head_view = flip_bus(bus_s);
	logic [4:0] head_reg;
	logic media_reg;
	logic offset_reg;
	logic offset_fwd_reg;
	logic offset_cmd_reg;

	// Rezero and head clear win over a head step in the same cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			head_reg <= HEAD_RESET;
			media_reg <= 1'b0;
			offset_reg <= 1'b0;
			offset_fwd_reg <= 1'b0;
			offset_cmd_reg <= 1'b0;
		end else if (do_rezero) begin
			head_reg <= HEAD_RESET;
			offset_reg <= 1'b0;
			offset_cmd_reg <= 1'b0;
		end else if (head_only) begin
			head_reg <= head_view[4:0];
			media_reg <= bus_s[HB_MEDIA];
			offset_reg <= bus_s[HB_OFFSET];
			offset_fwd_reg <= bus_s[HB_TOWARD_SPINDLE];
			offset_cmd_reg <= bus_s[HB_OFFSET];
		end else if (do_head_clear) begin
			head_reg <= HEAD_RESET;
		end else if (do_head_step) begin
			head_reg <= head_reg + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Ready hold-off after an offset command.

	// Counts from the head tag's trailing edge; ready stays off meanwhile.
	logic [31:0] settle_reg;
	wire settling = (settle_reg != 32'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_reg <= 32'h0;
		end else if (head_fall & offset_cmd_reg) begin
			settle_reg <= 32'(SETTLE_CYC);
		end else if (settling) begin
			settle_reg <= settle_reg - 32'h1;
		end
	end

	wire drive_ready = ready_s & ~settling & ~seek_reg;

	////////////////////////////////////////////////////////////////////////
	// Fault latches.

	wire rd = cmd_reg[CB_READ];
	wire wr = cmd_reg[CB_WRITE];
	logic [FLT_W-1:0] fault_set;
	always_comb begin
		fault_set = '0;
		fault_set[FLT_WRITE_UNSAFE] = wunsafe_s & wr;
		fault_set[FLT_CYL_NOT_READY] = cyl_rise & ~drive_ready;
		fault_set[FLT_RW_NOT_READY] = (rd | wr) & ~drive_ready;
		fault_set[FLT_OFFSET_WRITE] = offset_reg & wr;
		fault_set[FLT_READ_AND_WRITE] = rd & wr;
		fault_set[FLT_WRITE_PROTECT] = wr & read_only_s;
		fault_set[FLT_ILLEGAL_CYL] = illcyl_s;
		fault_set[FLT_GUARDBAND] = guard_s;
		fault_set[FLT_RETRACT] = retract_s;
		fault_set[FLT_SEEK_INC] = seekinc_s;
	end

	// Clear spares the retract latch; a live condition sets again at once.
	wire [FLT_W-1:0] clear_mask = {FLT_W{do_fault_clear | do_rezero}} &
		~(10'h001 << FLT_RETRACT);
	logic [FLT_W-1:0] fault_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_reg <= FLT_RESET;
		end else begin
			fault_reg <= (fault_reg & ~clear_mask) | fault_set;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address mark pulse.

	// Only a rising mark with mark enable already set yields a pulse.
	logic mark_q_reg;
	logic mark_pulse_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mark_q_reg <= 1'b0;
			mark_pulse_reg <= 1'b0;
		end else begin
			mark_q_reg <= mark_s;
			mark_pulse_reg <= mark_s & ~mark_q_reg & rd &
				cmd_reg[CB_MARK_ENABLE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cable status outputs.

	// Registered, and all but the terminator line gated by select: three cycles from the select pin,
	// well inside the allowed settling time.
	logic fault_n_reg;
	logic mark_n_reg;
	logic ready_n_reg;
	logic term_n_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_n_reg <= 1'b1;
			mark_n_reg <= 1'b1;
			ready_n_reg <= 1'b1;
			term_n_reg <= 1'b1;
		end else begin
			fault_n_reg <= ~(select_s & (|fault_reg));
			mark_n_reg <= ~(select_s & mark_pulse_reg);
			ready_n_reg <= ~(select_s & drive_ready);
			term_n_reg <= ~term_ok_s;
		end
	end

	assign fault_line_n = fault_n_reg;
	assign mark_found_pulse_n = mark_n_reg;
	assign ready_n = ready_n_reg;
	assign terminator_present_n = term_n_reg;

	// Command outputs come straight from their registers.
	assign cylinder_addr = cyl_reg;
	assign seek_start = seek_reg;
	assign head_addr = head_reg;
	assign media_select = media_reg;
	assign offset_request = offset_reg;
	assign offset_toward_spindle = offset_fwd_reg;
	assign strobe_late = cmd_reg[CB_STROBE_LATE];
	assign strobe_early = cmd_reg[CB_STROBE_EARLY];
	assign write_gate = wr;
	assign read_gate = rd;
	assign mark_enable = cmd_reg[CB_MARK_ENABLE];
	assign head_select_enable = cmd_reg[CB_HEAD_SELECT];

	// Rezero is a one-cycle command to the positioner.
	logic rezero_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rezero_reg <= 1'b0;
		end else begin
			rezero_reg <= do_rezero;
		end
	end
	assign rezero = rezero_reg;

	////////////////////////////////////////////////////////////////////////
	// APB slave.

	// Zero wait states; writes land at the access cycle.
	wire acc = psel & penable;
	wire hit_ctrl = (paddr == REG_CTRL);
	wire hit_fault = (paddr == REG_FAULT);
	wire hit_cyl = (paddr == REG_CYL);
	wire hit_head = (paddr == REG_HEAD);
	wire hit_cmd = (paddr == REG_CMD);
	wire hit_any = hit_ctrl | hit_fault | hit_cyl | hit_head | hit_cmd;

	// Writing bit 0 of the control word clears faults like the cable
	// command does; the retract latch is still kept.
	assign sw_clear = acc & pwrite & hit_ctrl & pwdata[0];

	// Read mux: drive state and latched commands.
	wire [31:0] rd_mux = hit_fault ? {22'h0, fault_reg} :
		hit_cyl ? {22'h0, cyl_reg} :
		hit_head ? {24'h0, offset_fwd_reg, offset_reg, media_reg, head_reg} :
		hit_cmd ? {20'h0, ~ready_n_reg, settling, cmd_reg} :
		32'h0;

	assign pready = 1'b1;
	assign pslverr = acc & ~hit_any;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= rd_mux;
		end
	end
endmodule
`default_nettype wire

// File: tb/tbd_properties.sv
// Checker that watches the cable outputs of the tag bus decoder.
`timescale 1ns/1ps
`default_nettype none
module tbd_properties (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Cable side.
	input wire logic cylinder_tag_n,
	input wire logic head_tag_n,
	input wire logic drive_select_n,
	input wire logic terminator_chain_ok,
	input wire logic emergency_retract,
	input wire logic fault_line_n,
	input wire logic terminator_present_n,
	input wire logic mark_found_pulse_n,
	input wire logic ready_n,
	// Drive side.
	input wire logic seek_start,
	input wire logic offset_request,
	input wire logic read_gate,
	input wire logic mark_enable,
	input wire logic rezero
);
	logic [2:0] sel_cnt; // Selected cycles, saturating at seven.
	logic [3:0] ret_sh; // Delays retract past the synchroniser.
	logic ret_seen; // Retract seen; only reset may forget it.
	////////////////////////////////////////////////////////////////////////
	// Helper state is kept short so the properties stay readable.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_cnt <= 3'h0;
			ret_sh <= 4'h0;
			ret_seen <= 1'b0;
		end else begin
			sel_cnt <= drive_select_n ? 3'h0 : sel_cnt + {2'h0, sel_cnt != 3'h7};
			ret_sh <= {ret_sh[2:0], emergency_retract};
			ret_seen <= ret_seen | ret_sh[3];
		end
	end
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_TERM_LOW: assert property (terminator_chain_ok [*5] |-> !terminator_present_n)
		else $error("terminator line not low");
	AST_TERM_HIGH: assert property (!terminator_chain_ok [*5] |-> terminator_present_n)
		else $error("terminator line low without chain");
	AST_GATED: assert property (drive_select_n [*4] |-> fault_line_n && mark_found_pulse_n && ready_n)
		else $error("status shown while deselected");
	AST_SEL_200NS: assert property ($fell(drive_select_n) && ret_seen |-> ##[1:20] !fault_line_n)
		else $error("fault line late after select");
	AST_RETRACT_HELD: assert property (ret_seen && sel_cnt == 3'h7 |-> !fault_line_n)
		else $error("retract fault lost");
	AST_PULSE_ONE: assert property ($fell(mark_found_pulse_n) |=> mark_found_pulse_n)
		else $error("mark pulse longer than one cycle");
	AST_PULSE_ENABLED: assert property (!mark_found_pulse_n |-> $past(mark_enable, 2) && $past(read_gate, 2))
		else $error("mark pulse without enable");
	AST_SEEK: assert property ($rose(cylinder_tag_n) |-> ##[2:5] seek_start)
		else $error("no seek after cylinder tag");
	AST_OFFSET_READY: assert property ($rose(head_tag_n) && offset_request |-> ##5 ready_n [*8])
		else $error("ready during offset settle");
	AST_REZERO_OFFSET: assert property (rezero |-> ##[0:2] !offset_request)
		else $error("offset kept after rezero");
endmodule
bind tbd_decoder tbd_properties chk (.pclk, .presetn, .cylinder_tag_n,
	.head_tag_n, .drive_select_n, .terminator_chain_ok, .emergency_retract,
	.fault_line_n, .terminator_present_n, .mark_found_pulse_n, .ready_n,
	.seek_start, .offset_request, .read_gate, .mark_enable, .rezero);
`default_nettype wire

// File: tb/tbd_ctrl_model.sv
// Controller model that drives the tags and bus of the cable.
`timescale 1ns/1ps
`default_nettype none
module tbd_ctrl_model (
	// Clock.
	input wire logic pclk,
	// Cable tags and bus, active low.
	output logic cylinder_tag_n,
	output logic head_tag_n,
	output logic control_tag_n,
	output logic [9:0] bus_n
);
	// Released lines sit at the terminator's pull-up level.
	initial begin
		cylinder_tag_n = 1'b1;
		head_tag_n = 1'b1;
		control_tag_n = 1'b1;
		bus_n = 10'h3ff;
	end
	// Mask bit 0 cylinder, bit 1 head, bit 2 control; extra slows the tag.
	task automatic send(input logic [2:0] mask, input logic [9:0] lines,
		input int extra);
		logic [9:0] l;
		l = lines;
		if (mask[1] && l[4])
			l[9:5] = 5'h00;
		@(posedge pclk);
		bus_n <= ~l;
		cylinder_tag_n <= !mask[0];
		head_tag_n <= !mask[1];
		control_tag_n <= !mask[2];
		repeat (80 + extra) @(posedge pclk);
		cylinder_tag_n <= 1'b1;
		head_tag_n <= 1'b1;
		control_tag_n <= 1'b1;
		repeat (2) @(posedge pclk);
		bus_n <= 10'h3ff;
		repeat (100) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// File: tb/test_disk_drive_tag_bus_decoder.sv
// Self-checking testbench for the tag bus decoder.
`timescale 1ns/1ps
`default_nettype none
module test_disk_drive_tag_bus_decoder;
	import tbd_pkg::*;
	localparam int SETTLE = 50; // Short hold-off keeps the run brief.
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'h3b94d4ae;
	logic pready, pslverr, fault_line_n, terminator_present_n;
	wire logic cylinder_tag_n, head_tag_n, control_tag_n;
	wire logic [9:0] bus_n;
	logic drive_select_n = 1'b1, terminator_chain_ok = 1'b0;
	logic heads_ready = 1'b1, read_only = 1'b0, address_mark_seen = 1'b0;
	logic write_unsafe = 1'b0, illegal_cylinder = 1'b0;
	logic guardband_on_track = 1'b0, emergency_retract = 1'b0;
	logic seek_incomplete = 1'b0, mark_found_pulse_n, ready_n;
	logic [9:0] cylinder_addr;
	logic [4:0] head_addr;
	logic seek_start, media_select, offset_request, offset_toward_spindle;
	logic strobe_late, strobe_early, write_gate, read_gate, mark_enable;
	logic head_select_enable, rezero;
	int fail_count = 0, comparisons = 0;
	int lv[6] = '{0, 1, 2, 3, 4, 7}; // Level bits of the control tag.
	tbd_decoder #(.SETTLE_CYC(SETTLE)) dut (.*);
	tbd_ctrl_model ctl (.*);
	always #5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Bus line i carries the bit of weight 2**(9-i).
	function automatic logic [9:0] rev10(input logic [9:0] x);
		for (int i = 0; i < 10; i++)
			rev10[i] = x[9 - i];
	endfunction
	function automatic logic [5:0] ctl_exp(input int j);
		return (j == 7) ? 6'h20 : 6'h01 << j;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Waits whole cycles; callers then drive inputs on the edge itself.
	task automatic w(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One APB transfer, launched just after a clock edge so that a release
	// and the next setup never fall in one time step; the wait on pready
	// is cut short by the watchdog.
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic clr();
		logic [31:0] q;
		logic e;
		apb(1'b1, REG_CTRL, 32'h1, q, e);
		w(6);
	endtask
	task automatic mark_pulse(output int n);
		n = 0;
		address_mark_seen <= 1'b1;
		repeat (12) begin
			w(1);
			if (mark_found_pulse_n === 1'b0)
				n++;
		end
		address_mark_seen <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (30000) @(posedge pclk);
		fail_count++;
		tally_and_finish();
	end
	// Main sequence; random values mix with fixed corner cases.
	initial begin
		logic [31:0] q, v;
		logic e;
		int n;
		w(12);
		presetn <= 1'b1;
		w(6);
		check({fault_line_n, mark_found_pulse_n, terminator_present_n}, 7);
		apb(1'b0, REG_HEAD, 0, q, e);
		check(q[4:0], HEAD_RESET);
		apb(1'b0, 8'h20, 0, q, e);
		check(e, 1);
		terminator_chain_ok <= 1'b1;
		w(6);
		check(terminator_present_n, 0);
		drive_select_n <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 32'h200 : (i == 1) ? 32'h1 : xs();
			ctl.send(3'h1, rev10(v[9:0]), i * 7);
			check(cylinder_addr, v[9:0]);
		end
		heads_ready <= 1'b0;
		ctl.send(3'h1, 10'h0, 0);
		heads_ready <= 1'b1;
		check(fault_line_n, 0);
		clr();
		check(fault_line_n, 1);
		for (int i = 0; i < 5; i++) begin
			v = xs();
			if (i < 3)
				v[6:5] = (i == 0) ? 2'h3 : (i == 1) ? 2'h1 : 2'h0;
			ctl.send(3'h2, rev10({5'h0, v[4:0]}) | {6'h0, v[6:5], 2'h0}, i);
			check({media_select, head_addr}, {v[3], v[4:0]});
			check(offset_request, v[5]);
			if (v[5])
				check(offset_toward_spindle, v[6]);
			check(ready_n, 0);
		end
		ctl.send(3'h4, 10'h100, 0);
		check({offset_request, head_addr}, 0);
		ctl.send(3'h4, 10'h200, 0);
		ctl.send(3'h4, 10'h200, 0);
		check(head_addr, 2);
		ctl.send(3'h4, 10'h020, 0);
		check(head_addr, 0);
		foreach (lv[k]) begin
			ctl.send(3'h4, 10'h1 << lv[k], 0);
			check({head_select_enable, mark_enable, read_gate, write_gate,
				strobe_early, strobe_late}, ctl_exp(lv[k]));
		end
		ctl.send(3'h4, 10'h00c, 0);
		apb(1'b0, REG_FAULT, 0, q, e);
		check({fault_line_n, q[FLT_READ_AND_WRITE]}, 1);
		ctl.send(3'h4, 10'h0, 0);
		ctl.send(3'h4, 10'h040, 0);
		check(fault_line_n, 1);
		for (int k = 0; k < 3; k++) begin
			{seek_incomplete, guardband_on_track, illegal_cylinder} <= 3'h1 << k;
			w(8);
			{seek_incomplete, guardband_on_track, illegal_cylinder} <= 3'h0;
			apb(1'b0, REG_FAULT, 0, q, e);
			check(q[9:0], 10'h1 << ((k == 0) ? FLT_ILLEGAL_CYL :
				(k == 1) ? FLT_GUARDBAND : FLT_SEEK_INC));
			clr();
			check(fault_line_n, 1);
		end
		// Gate faults: write protect, write unsafe, not ready, offset write.
		for (int k = 0; k < 4; k++) begin
			{heads_ready, write_unsafe, read_only} <= (k == 0) ? 3'h5 :
				(k == 1) ? 3'h6 : (k == 2) ? 3'h0 : 3'h4;
			if (k == 3)
				ctl.send(3'h2, 10'h004, 0);
			ctl.send(3'h4, (k == 2) ? 10'h008 : 10'h004, 0);
			apb(1'b0, REG_FAULT, 0, q, e);
			check(q[9:0], 10'h1 << ((k == 0) ? FLT_WRITE_PROTECT :
				(k == 1) ? FLT_WRITE_UNSAFE : (k == 2) ? FLT_RW_NOT_READY :
				FLT_OFFSET_WRITE));
			ctl.send(3'h4, 10'h0, 0);
			{heads_ready, write_unsafe, read_only} <= 3'h4;
			clr();
			check(fault_line_n, 1);
		end
		emergency_retract <= 1'b1;
		w(8);
		emergency_retract <= 1'b0;
		ctl.send(3'h4, 10'h040, 0);
		check(fault_line_n, 0);
		drive_select_n <= 1'b1;
		w(6);
		check(fault_line_n, 1);
		drive_select_n <= 1'b0;
		w(20);
		check(fault_line_n, 0);
		ctl.send(3'h4, 10'h100, 0);
		check(fault_line_n, 0);
		presetn <= 1'b0;
		w(3);
		presetn <= 1'b1;
		w(6);
		check(fault_line_n, 1);
		ctl.send(3'h4, 10'h018, 0);
		mark_pulse(n);
		check(n, 1);
		ctl.send(3'h4, 10'h008, 0);
		mark_pulse(n);
		check(n, 0);
		ctl.send(3'h6, 10'h381, 0);
		check({strobe_late, head_addr}, {1'b0, HEAD_RESET});
		tally_and_finish();
	end
endmodule
`default_nettype wire
